// *** rtl/fdchx_xfer.sv ***
// Floppy controller host side: command bytes, execution transfer
// by DMA, interrupt or polling, and result bytes.
// Assumes a disk engine that consumes cmd and returns status and data.
//
// How it works
// RULE_01: DMA mode requests each ready execution byte
// RULE_02: DMA needs specify bit and drive-control gate
// RULE_03: DMA partner answers with acknowledge plus strobe
// RULE_04: Request drops on acknowledge going low
// RULE_05: DMA mode interrupts on entering result phase
// RULE_06: Host keeps chip select high during DMA
// RULE_07: Terminal count ends operation, only with acknowledge
// RULE_08: Non-DMA interrupts per byte, status bits 5,7
// RULE_09: Byte interrupt clears when byte is moved
// RULE_10: Late service flags overrun, ends at sector end
// RULE_11: Interrupt marks result phase, status bits 7,6
// RULE_12: First result read clears result interrupt
// RULE_13: Status bit 7 mirrors interrupt in non-DMA
// RULE_14: Transfer commands take nine bytes, return seven
// RULE_15: Low five opcode bits pick the command
// RULE_16: Format six bytes, read ID two bytes
// RULE_17: Scan equal last byte is step size
// RULE_18: Host services each byte within rate limit
// RULE_19: Implied seek honoured only when mode enables
// RULE_20: Command writes and result reads gated by status
// RULE_21: No per-byte interrupts in DMA mode
`include "fdchx_cfg.svh"
module fdchx_xfer
  import fdchx_pkg::*;
#(
  parameter int SVC125_CYC = `FDCHX_SVC125_NS / `FDCHX_MCLK_NS,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Host data register
  input wire logic cs_n,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [7:0] msr,
  // DMA and interrupt
  input wire logic dma_ack_n,
  input wire logic terminal_count,
  output logic dma_request,
  output logic irq,
  // Configuration
  input wire logic dma_mode_bit,
  input wire logic dma_gate_en,
  input wire logic implied_seek_en,
  input wire logic [1:0] rate_sel,
  // Engine command side
  output logic cmd_start,
  output fdchx_cmd_t cmd,
  output logic exec_abort,
  input wire logic exec_done,
  input wire logic sector_end,
  input wire fdchx_res_t res_in,
  // Engine data side
  input wire logic disk_rd_valid,
  input wire logic [7:0] disk_rd_data,
  output logic disk_rd_ready,
  output logic disk_wr_valid,
  output logic [7:0] disk_wr_data,
  input wire logic disk_wr_ready
);
  fdchx_phase_t phase_reg;
  logic [3:0] idx_reg;
  logic [7:0] cbuf_reg [0:8];
  logic [6:0][7:0] rbuf_reg;
  logic [3:0] res_len_reg;
  logic to_host_reg;
  logic xfer_reg;
  logic launch_reg;
  logic cmd_start_reg;
  logic exec_abort_reg;
  fdchx_cmd_t cmd_reg;
  logic dreq_reg;
  logic irq_reg;
  logic res_irq_reg;
  logic ovr_reg;
  logic [12:0] svc_cnt_reg;
  logic [7:0] msr_reg;
  logic [7:0] msr_next;
  logic [7:0] rdata_reg;

  logic in_cmd;
  logic in_exec;
  logic in_res;
  logic dma_on;
  logic acc;
  logic cmd_wr;
  logic res_rd;
  logic rd_take;
  logic wr_take;
  logic byte_ready;
  logic byte_irq;
  logic irq_comb;
  logic tc_hit;
  logic ovr_end;
  logic end_exec;
  logic last_cmd;
  logic [12:0] svc_lim;
  logic [7:0] opc_sel;
  fdchx_op_t dec_op;
  logic [3:0] dec_cmd_len;
  logic [3:0] dec_res_len;
  logic dec_xfer;
  logic dec_to_host;
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;

  // ----------------------------------------
  // Phase and access decode
  // ----------------------------------------
  assign in_cmd = (phase_reg == PH_CMD);
  assign in_exec = (phase_reg == PH_EXEC);
  assign in_res = (phase_reg == PH_RES);
  assign dma_on = dma_mode_bit & dma_gate_en; // [RULE_02]
  // Chip select stays high under DMA, so acknowledge selects alone
  assign acc = ~cs_n | ~dma_ack_n; // [RULE_03] [RULE_06]
  assign cmd_wr = in_cmd & wr_strobe & ~cs_n; // [RULE_20]
  assign res_rd = in_res & rd_strobe & ~cs_n; // [RULE_20]
  assign rd_take = in_exec & xfer_reg & to_host_reg & rd_strobe & acc & f_out_valid;
  assign wr_take = in_exec & xfer_reg & ~to_host_reg & wr_strobe & acc & f_in_ready;
  assign byte_ready = in_exec & xfer_reg & (to_host_reg ? f_out_valid : f_in_ready);
  assign tc_hit = in_exec & terminal_count & ~dma_ack_n; // [RULE_07]
  assign ovr_end = in_exec & ovr_reg & sector_end; // [RULE_10]
  assign end_exec = in_exec & (exec_done | tc_hit | ovr_end);
  assign last_cmd = cmd_wr & (idx_reg == dec_cmd_len - 4'h1);

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  assign opc_sel = (in_cmd && idx_reg == 4'h0) ? wdata : cbuf_reg[0];

  fdchx_opdec u_dec (
    .opcode(opc_sel),
    .op(dec_op),
    .cmd_len(dec_cmd_len),
    .res_len(dec_res_len),
    .xfer(dec_xfer),
    .to_host(dec_to_host)
  );

  // ----------------------------------------
  // Data FIFO
  // ----------------------------------------
  // One FIFO serves both directions; it is flushed outside execution
  assign f_in_valid = to_host_reg ? (in_exec & xfer_reg & disk_rd_valid) : wr_take;
  assign f_in_data = to_host_reg ? disk_rd_data : wdata;
  assign f_out_ready = to_host_reg ? rd_take : (in_exec & xfer_reg & disk_wr_ready);
  assign disk_rd_ready = in_exec & xfer_reg & to_host_reg & f_in_ready;
  assign disk_wr_valid = in_exec & xfer_reg & ~to_host_reg & f_out_valid;
  assign disk_wr_data = f_out_data;

  fdchx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(~in_exec),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= PH_CMD;
      idx_reg <= 4'h0;
      to_host_reg <= 1'b1;
      xfer_reg <= 1'b0;
      res_len_reg <= `FDCHX_LEN_RES;
    end else begin
      case (phase_reg)
        PH_CMD: begin
          if (last_cmd) begin
            idx_reg <= 4'h0;
            to_host_reg <= dec_to_host;
            xfer_reg <= dec_xfer;
            res_len_reg <= dec_res_len;
            phase_reg <= (dec_op == OP_INVALID) ? PH_RES : PH_EXEC;
          end else if (cmd_wr) begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        PH_EXEC: begin
          if (end_exec) begin
            phase_reg <= PH_RES; // [RULE_05] [RULE_07]
          end
        end
        default: begin
          if (res_rd && idx_reg == res_len_reg - 4'h1) begin
            idx_reg <= 4'h0;
            phase_reg <= PH_CMD;
          end else if (res_rd) begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Command bytes and engine hand-off
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (cmd_wr) begin
      cbuf_reg[idx_reg] <= wdata; // [RULE_14]
    end
  end

  // Start is held back one edge so the last byte has landed in cbuf
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      launch_reg <= 1'b0;
      cmd_start_reg <= 1'b0;
      exec_abort_reg <= 1'b0;
    end else begin
      launch_reg <= last_cmd & (dec_op != OP_INVALID);
      cmd_start_reg <= launch_reg;
      exec_abort_reg <= in_exec & ~exec_done & (tc_hit | ovr_end);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= '0;
    end else if (launch_reg) begin
      cmd_reg.op <= dec_op;
      cmd_reg.multi_track <= cbuf_reg[0][`FDCHX_B0_MT];
      cmd_reg.double_density_select <= cbuf_reg[0][`FDCHX_B0_DD];
      cmd_reg.skip_deleted <= cbuf_reg[0][`FDCHX_B0_SK];
      cmd_reg.implied_seek <= cbuf_reg[1][`FDCHX_B1_IPS] & implied_seek_en; // [RULE_19]
      cmd_reg.head_select <= cbuf_reg[1][`FDCHX_B1_HD];
      cmd_reg.drive_sel_hi <= cbuf_reg[1][`FDCHX_B1_DR1];
      cmd_reg.drive_sel_lo <= cbuf_reg[1][`FDCHX_B1_DR0];
      cmd_reg.prm <= {cbuf_reg[2], cbuf_reg[3], cbuf_reg[4], cbuf_reg[5],
                      cbuf_reg[6], cbuf_reg[7], cbuf_reg[8]}; // [RULE_16] [RULE_17]
    end
  end

  // ----------------------------------------
  // Result bytes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rbuf_reg <= '0;
    end else if (last_cmd && dec_op == OP_INVALID) begin
      rbuf_reg[6] <= `FDCHX_ST0_INVALID;
    end else if (end_exec) begin
      rbuf_reg <= res_in; // [RULE_14]
      if (ovr_reg) begin
        rbuf_reg[6] <= res_in.st0 | `FDCHX_ST0_ABNORMAL; // [RULE_10]
        rbuf_reg[5] <= res_in.st1 | `FDCHX_ST1_OVERRUN;
      end
    end
  end

  // ----------------------------------------
  // DMA request
  // ----------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dreq_reg <= 1'b0;
    end else begin
      // Low acknowledge forces the request off [RULE_04]
      dreq_reg <= dma_ack_n & dma_on & byte_ready; // [RULE_01] [RULE_02]
    end
  end

  // ----------------------------------------
  // Service timer and overrun
  // ----------------------------------------
  always_comb begin
    case (rate_sel)
      `FDCHX_RATE_125: svc_lim = 13'(SVC125_CYC);
      `FDCHX_RATE_250: svc_lim = 13'(`FDCHX_SVC250_CYC);
      `FDCHX_RATE_500: svc_lim = 13'(`FDCHX_SVC500_CYC);
      default: svc_lim = 13'(`FDCHX_SVC1K_CYC);
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      svc_cnt_reg <= 13'h0000;
      ovr_reg <= 1'b0;
    end else begin
      if (byte_ready && !(rd_take || wr_take) && !ovr_reg) begin
        svc_cnt_reg <= svc_cnt_reg + 13'h0001;
      end else begin
        svc_cnt_reg <= 13'h0000;
      end
      // Overrun is only reported; the sector still runs to its end
      if (in_cmd) begin
        ovr_reg <= 1'b0;
      end else if (byte_ready && svc_cnt_reg == svc_lim - 13'h0001) begin
        ovr_reg <= 1'b1; // [RULE_10] [RULE_18]
      end
    end
  end

  // ----------------------------------------
  // Interrupt and main status
  // ----------------------------------------
  assign byte_irq = byte_ready & ~dma_on; // [RULE_08] [RULE_09] [RULE_21]
  assign irq_comb = byte_irq | res_irq_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      res_irq_reg <= 1'b0;
    end else if ((last_cmd && dec_op == OP_INVALID) || end_exec) begin
      res_irq_reg <= 1'b1; // [RULE_05] [RULE_11]
    end else if (res_rd && idx_reg == 4'h0) begin
      res_irq_reg <= 1'b0; // [RULE_12]
    end
  end

  always_comb begin
    msr_next = 8'h00;
    msr_next[`FDCHX_MSR_RQM] = in_cmd | in_res | (in_exec & ~dma_on & irq_comb); // [RULE_13]
    msr_next[`FDCHX_MSR_DIO] = in_res | (in_exec & ~dma_on & to_host_reg & irq_comb);
    msr_next[`FDCHX_MSR_NDMA] = in_exec & ~dma_on; // [RULE_08] [RULE_11]
    msr_next[`FDCHX_MSR_BUSY] = ~in_cmd | (idx_reg != 4'h0);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
      msr_reg <= 8'h80;
    end else begin
      irq_reg <= irq_comb;
      msr_reg <= msr_next;
    end
  end

  // Read data is staged ahead so a strobe sees it at once
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (in_res) begin
      rdata_reg <= rbuf_reg[3'(4'h6 - idx_reg)];
    end else begin
      rdata_reg <= f_out_data;
    end
  end

  assign rdata = rdata_reg;
  assign msr = msr_reg;
  assign irq = irq_reg;
  assign dma_request = dreq_reg;
  assign cmd_start = cmd_start_reg;
  assign cmd = cmd_reg;
  assign exec_abort = exec_abort_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_req_set;
    @(posedge mclk) disable iff (!reset_n)
      dma_on && byte_ready && dma_ack_n |=> dma_request;
  endproperty
  a_req_set: assert property (p_req_set) else $error("no dma request"); // [RULE_01]

  property p_req_gate;
    @(posedge mclk) disable iff (!reset_n)
      dma_request |-> $past(dma_mode_bit && dma_gate_en);
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("ungated dma"); // [RULE_02]

  property p_req_drop;
    @(posedge mclk) disable iff (!reset_n)
      $fell(dma_ack_n) |=> !dma_request;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held"); // [RULE_04]

  property p_dma_res_irq;
    @(posedge mclk) disable iff (!reset_n)
      in_exec && dma_on && exec_done |-> ##2 irq;
  endproperty
  a_dma_res_irq: assert property (p_dma_res_irq) else $error("no result irq"); // [RULE_05]

  property p_tc;
    @(posedge mclk) disable iff (!reset_n)
      in_exec && terminal_count && !dma_ack_n |=> in_res;
  endproperty
  a_tc: assert property (p_tc) else $error("tc ignored"); // [RULE_07]

  property p_tc_gated;
    @(posedge mclk) disable iff (!reset_n)
      in_exec && dma_ack_n && !exec_done && !ovr_end |=> in_exec;
  endproperty
  a_tc_gated: assert property (p_tc_gated) else $error("left exec"); // [RULE_07]

  property p_byte_irq;
    @(posedge mclk) disable iff (!reset_n)
      byte_ready && !dma_on |=> irq && msr[7] && msr[5];
  endproperty
  a_byte_irq: assert property (p_byte_irq) else $error("no byte irq"); // [RULE_08]

  property p_ovr;
    @(posedge mclk) disable iff (!reset_n)
      in_exec && ovr_reg && sector_end |=> in_res && rbuf_reg[5][`FDCHX_ST1_OVR_BIT];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun lost"); // [RULE_10]

  property p_res_msr;
    @(posedge mclk) disable iff (!reset_n)
      in_res |=> msr[7:5] == 3'b110;
  endproperty
  a_res_msr: assert property (p_res_msr) else $error("bad result status"); // [RULE_11]

  property p_res_clr;
    @(posedge mclk) disable iff (!reset_n)
      res_rd && idx_reg == 4'h0 |-> ##2 !irq;
  endproperty
  a_res_clr: assert property (p_res_clr) else $error("irq not cleared"); // [RULE_12]

  property p_mirror;
    @(posedge mclk) disable iff (!reset_n)
      $past(in_exec && !dma_on) |-> msr[7] == irq;
  endproperty
  a_mirror: assert property (p_mirror) else $error("status 7 not irq"); // [RULE_13]

  property p_no_dma_irq;
    @(posedge mclk) disable iff (!reset_n)
      in_exec && dma_on && !res_irq_reg |=> !irq;
  endproperty
  a_no_dma_irq: assert property (p_no_dma_irq) else $error("byte irq in dma"); // [RULE_21]
endmodule

// *** rtl/fdchx_cfg.svh ***
// Constants of the floppy host transfer and command block.
// Assumes inclusion by bare name from every rtl file that needs it.
`ifndef FDCHX_CFG_SVH
`define FDCHX_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FDCHX_MCLK_NS 8
`define FDCHX_SVC125_NS 62000
`define FDCHX_SVC250_NS 30000
`define FDCHX_SVC500_NS 14000
`define FDCHX_SVC1K_NS 6000
`define FDCHX_SVC250_CYC (`FDCHX_SVC250_NS / `FDCHX_MCLK_NS)
`define FDCHX_SVC500_CYC (`FDCHX_SVC500_NS / `FDCHX_MCLK_NS)
`define FDCHX_SVC1K_CYC (`FDCHX_SVC1K_NS / `FDCHX_MCLK_NS)

// ----------------------------------------
// Data rate select codes
// ----------------------------------------
`define FDCHX_RATE_125 2'h0
`define FDCHX_RATE_250 2'h1
`define FDCHX_RATE_500 2'h2
`define FDCHX_RATE_1K 2'h3

// ----------------------------------------
// Opcodes, low five bits
// ----------------------------------------
`define FDCHX_OPC_READ 5'h06
`define FDCHX_OPC_READ_DEL 5'h0C
`define FDCHX_OPC_WRITE 5'h05
`define FDCHX_OPC_READ_ID 5'h0A
`define FDCHX_OPC_FORMAT 5'h0D
`define FDCHX_OPC_SCAN_EQ 5'h11
`define FDCHX_OPC_READ_TRK 5'h02

// ----------------------------------------
// Byte counts
// ----------------------------------------
`define FDCHX_LEN_XFER 4'h9
`define FDCHX_LEN_READ_ID 4'h2
`define FDCHX_LEN_FORMAT 4'h6
`define FDCHX_LEN_ONE 4'h1
`define FDCHX_LEN_RES 4'h7

// ----------------------------------------
// Field positions and status values
// ----------------------------------------
`define FDCHX_B0_MT 7
`define FDCHX_B0_DD 6
`define FDCHX_B0_SK 5
`define FDCHX_B1_IPS 7
`define FDCHX_B1_HD 2
`define FDCHX_B1_DR1 1
`define FDCHX_B1_DR0 0
`define FDCHX_MSR_RQM 7
`define FDCHX_MSR_DIO 6
`define FDCHX_MSR_NDMA 5
`define FDCHX_MSR_BUSY 4
`define FDCHX_ST0_INVALID 8'h80
`define FDCHX_ST0_ABNORMAL 8'h40
`define FDCHX_ST1_OVR_BIT 4
`define FDCHX_ST1_OVERRUN 8'h10

`endif

// *** rtl/fdchx_pkg.sv ***
// Types of the floppy host transfer and command block.
// Assumes nothing beyond a SystemVerilog compiler.
package fdchx_pkg;

  typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} fdchx_phase_t;

  typedef enum logic [3:0] {
    OP_READ, OP_READ_DEL, OP_WRITE, OP_READ_ID,
    OP_FORMAT, OP_SCAN_EQ, OP_READ_TRK, OP_INVALID
  } fdchx_op_t;

  typedef struct packed {
    fdchx_op_t op;
    logic multi_track;
    logic double_density_select;
    logic skip_deleted;
    logic implied_seek;
    logic head_select;
    logic drive_sel_hi;
    logic drive_sel_lo;
    logic [6:0][7:0] prm;
  } fdchx_cmd_t;

  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] track;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } fdchx_res_t;

endpackage

// *** rtl/fdchx_fifo.sv ***
// Byte FIFO in the execution-phase data path.
// Assumes one clock; flush empties it in one edge.
module fdchx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** rtl/fdchx_opdec.sv ***
// Opcode decoder: command kind, byte counts and data direction.
// Assumes the opcode byte is stable while its outputs are used.
`include "fdchx_cfg.svh"
module fdchx_opdec
  import fdchx_pkg::*;
(
  // Opcode in
  input wire logic [7:0] opcode,
  // Decode out
  output fdchx_op_t op,
  output logic [3:0] cmd_len,
  output logic [3:0] res_len,
  output logic xfer,
  output logic to_host
);
  always_comb begin
    op = OP_INVALID;
    cmd_len = `FDCHX_LEN_ONE;
    res_len = `FDCHX_LEN_RES;
    xfer = 1'b1;
    to_host = 1'b1;
    // Low five bits only; high bits are option flags [RULE_15]
    case (opcode[4:0])
      `FDCHX_OPC_READ: begin
        op = OP_READ;
        cmd_len = `FDCHX_LEN_XFER; // [RULE_14]
      end
      `FDCHX_OPC_READ_DEL: begin
        op = OP_READ_DEL;
        cmd_len = `FDCHX_LEN_XFER;
      end
      `FDCHX_OPC_WRITE: begin
        op = OP_WRITE;
        cmd_len = `FDCHX_LEN_XFER;
        to_host = 1'b0;
      end
      `FDCHX_OPC_READ_ID: begin
        op = OP_READ_ID;
        cmd_len = `FDCHX_LEN_READ_ID; // [RULE_16]
        xfer = 1'b0;
      end
      `FDCHX_OPC_FORMAT: begin
        op = OP_FORMAT;
        cmd_len = `FDCHX_LEN_FORMAT; // [RULE_16]
        to_host = 1'b0;
      end
      `FDCHX_OPC_SCAN_EQ: begin
        op = OP_SCAN_EQ;
        cmd_len = `FDCHX_LEN_XFER; // [RULE_17]
        to_host = 1'b0;
      end
      `FDCHX_OPC_READ_TRK: begin
        op = OP_READ_TRK;
        cmd_len = `FDCHX_LEN_XFER;
      end
      default: begin
        res_len = `FDCHX_LEN_ONE;
        xfer = 1'b0;
      end
    endcase
  end
endmodule

// *** verif/fdchx_dma_model.sv ***
// DMA controller model: answers each request with ack and a read strobe.
// Assumes the bench merges rd_pulse into the block's read strobe.
module fdchx_dma_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Request side
  input wire logic dma_request,
  input wire logic [7:0] rdata,
  // Pacing and count
  input wire logic [1:0] slow,
  input wire logic [3:0] tc_at,
  // Answer side
  output logic dma_ack_n,
  output logic rd_pulse,
  output logic terminal_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [$];
  logic [1:0] wait_reg;
  logic [3:0] cnt_reg;
  // ----------------
  // Answer
  // ----------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dma_ack_n <= 1'b1;
      rd_pulse <= 1'b0;
      terminal_count <= 1'b0;
      wait_reg <= 2'h0;
      cnt_reg <= 4'h0;
    end else if (!dma_ack_n) begin
      got.push_back(rdata);
      dma_ack_n <= 1'b1;
      rd_pulse <= 1'b0;
      terminal_count <= 1'b0;
    end else if (dma_request && wait_reg < slow) begin
      wait_reg <= wait_reg + 2'h1;
    end else if (dma_request) begin
      wait_reg <= 2'h0;
      dma_ack_n <= 1'b0;
      rd_pulse <= 1'b1;
      cnt_reg <= cnt_reg + 4'h1;
      // Count only rides with the ack, never alone
      terminal_count <= (cnt_reg + 4'h1 == tc_at);
    end
  end
endmodule

// *** verif/fdchx_xfer_tb.sv ***
// Bench: decode sweep, DMA moves, count stop, per-byte irq, overrun.
// Assumes the engine side is played here and the DMA model beside it.
module fdchx_xfer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fdchx_pkg::*;
  logic mclk = 0, reset_n = 0, cs_n = 1, tb_rd = 0, m_rd, wr_strobe = 0;
  logic dma_mode_bit = 1, dma_gate_en = 1, implied_seek_en = 0, exec_done = 0, sector_end = 0;
  logic disk_rd_valid = 0, disk_wr_ready = 1, dma_ack_n, terminal_count, dma_request, irq;
  logic cmd_start, exec_abort, disk_rd_ready, disk_wr_valid;
  logic [7:0] wdata = 8'h00, disk_rd_data = 8'h00, rdata, msr, disk_wr_data;
  logic [1:0] rate_sel = 2'h0, slow = 2'h0;
  logic [3:0] tc_at = 4'h0;
  logic [31:0] lf = 32'hEEF6;
  logic [7:0] b [9];
  logic [7:0] q [$];
  logic [4:0] lo [7] = '{5'h06, 5'h0C, 5'h05, 5'h0A, 5'h0D, 5'h11, 5'h02};
  int ln [7] = '{9, 9, 9, 2, 6, 9, 9};
  int err_total = 0, checked = 0;
  fdchx_cmd_t cmd;
  fdchx_res_t res = '0;
  always #4 mclk = ~mclk;
  fdchx_xfer #(.SVC125_CYC(20), .FIFO_DEPTH(8)) u_fdchx_xfer (
    .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .rd_strobe(tb_rd | m_rd),
    .wr_strobe(wr_strobe), .wdata(wdata), .rdata(rdata), .msr(msr), .dma_ack_n(dma_ack_n),
    .terminal_count(terminal_count), .dma_request(dma_request), .irq(irq),
    .dma_mode_bit(dma_mode_bit), .dma_gate_en(dma_gate_en), .implied_seek_en(implied_seek_en),
    .rate_sel(rate_sel), .cmd_start(cmd_start), .cmd(cmd), .exec_abort(exec_abort),
    .exec_done(exec_done), .sector_end(sector_end), .res_in(res),
    .disk_rd_valid(disk_rd_valid), .disk_rd_data(disk_rd_data), .disk_rd_ready(disk_rd_ready),
    .disk_wr_valid(disk_wr_valid), .disk_wr_data(disk_wr_data), .disk_wr_ready(disk_wr_ready));
  fdchx_dma_model u_fdchx_dma_model (.mclk(mclk), .reset_n(reset_n), .dma_request(dma_request),
    .rdata(rdata), .slow(slow), .tc_at(tc_at), .dma_ack_n(dma_ack_n), .rd_pulse(m_rd),
    .terminal_count(terminal_count));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [7:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[7:0];
  endfunction
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task conclude;
    $display("compares %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] v);
    cs_n = 0;
    wr_strobe = 1;
    wdata = v;
    tick;
    cs_n = 1;
    wr_strobe = 0;
    tick;
  endtask
  task rdb(input logic [7:0] e);
    chk(rdata, e);
    cs_n = 0;
    tb_rd = 1;
    tick;
    cs_n = 1;
    tb_rd = 0;
    repeat (2) tick;
  endtask
  task push(input int n);
    int k, w;
    disk_rd_valid = 1;
    for (k = 0; k < n; k++) begin
      disk_rd_data = rnd();
      q.push_back(disk_rd_data);
      for (w = 0; disk_rd_ready !== 1'b1 && w < 50; w++) tick;
      tick;
    end
    disk_rd_valid = 0;
  endtask
  task cmdw(input int i);
    int k;
    for (k = 0; k < 7; k++) res[8*k +: 8] = rnd();
    for (k = 0; k < ln[i]; k++) begin
      b[k] = rnd();
      if (k == 0) b[0][4:0] = lo[i];
      wr(b[k]);
    end
    for (k = 0; cmd_start !== 1'b1 && k < 20; k++) tick;
    chk(cmd_start, 1);
    chk(cmd.op, i);
    chk(cmd.double_density_select, b[0][6]);
    chk({cmd.head_select, cmd.drive_sel_hi, cmd.drive_sel_lo}, b[1][2:0]);
    if (i < 2) chk({cmd.multi_track, cmd.skip_deleted}, {b[0][7], b[0][5]});
    if (ln[i] == 9) begin
      chk(cmd.implied_seek, b[1][7] & implied_seek_en);
      chk(cmd.prm[6], b[2]);
      chk(cmd.prm[0], b[8]);
    end
  endtask
  task fin(input logic [7:0] o0, o1);
    int k;
    for (k = 0; (irq !== 1'b1 || msr[5] !== 1'b0) && k < 200; k++) tick;
    chk(msr[7:5], 3'h6);
    rdb(res.st0 | o0);
    chk(irq, 0);
    rdb(res.st1 | o1);
    for (k = 4; k >= 0; k--) rdb(res[8*k +: 8]);
    chk(msr, 8'h80);
  endtask
  task drain;
    while (u_fdchx_dma_model.got.size() > 0)
      chk(u_fdchx_dma_model.got.pop_front(), q.pop_front());
    q.delete();
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    int i, k;
    repeat (4) tick;
    reset_n = 1;
    chk(msr, 8'h80);
    // Sweep without DMA: no request is raised, so the model stays idle
    dma_gate_en = 0;
    for (i = 0; i < 7; i++) begin
      implied_seek_en = i[0];
      cmdw(i);
      exec_done = 1;
      tick;
      exec_done = 0;
      fin(8'h00, 8'h00);
    end
    dma_gate_en = 1;
    wr(8'h1F);
    for (k = 0; msr[6] !== 1'b1 && k < 20; k++) tick;
    rdb(8'h80);
    chk(msr, 8'h80);
    // Slow partner, cs_n left high while DMA moves the bytes
    slow = 2'h2;
    cmdw(0);
    push(3);
    for (k = 0; u_fdchx_dma_model.got.size() < 3 && k < 200; k++) tick;
    drain;
    chk(irq, 0);
    exec_done = 1;
    tick;
    exec_done = 0;
    fin(8'h00, 8'h00);
    slow = 2'h0;
    tc_at = 4'h5;
    cmdw(0);
    push(3);
    for (k = 0; exec_abort !== 1'b1 && k < 200; k++) tick;
    chk(exec_abort, 1);
    drain;
    fin(8'h00, 8'h00);
    dma_gate_en = 0;
    cmdw(0);
    push(1);
    for (k = 0; irq !== 1'b1 && k < 20; k++) tick;
    chk({msr[7], msr[5], dma_request}, 3'h6);
    rdb(q.pop_front());
    chk({irq, msr[7]}, 2'h0);
    push(1);
    q.delete();
    // Service left late on purpose
    repeat (30) tick;
    sector_end = 1;
    tick;
    sector_end = 0;
    fin(8'h40, 8'h10);
    // Host-to-disk byte, then left unserved at the fastest rate
    rate_sel = 2'h3;
    disk_wr_ready = 0;
    cmdw(2);
    chk({irq, msr[7:5]}, 4'hD);
    b[0] = rnd();
    wr(b[0]);
    chk({disk_wr_valid, disk_wr_data}, {1'b1, b[0]});
    repeat (760) tick;
    sector_end = 1;
    tick;
    sector_end = 0;
    fin(8'h40, 8'h10);
    disk_wr_ready = 1;
    conclude;
  end
  initial begin
    #400000;
    err_total++;
    conclude;
  end
endmodule
